// *** rtl/hlbp_host_port.sv ***
// Purpose: Byte-wide host register port to a processor link.
// Assumes: Host strobes are one-cycle pulses on clk_in.
// Notes: Link side is byte valid/ready on the same clock.
`timescale 1ns/100ps
module hlbp_host_port
   import hlbp_pkg::*;
#(
   parameter int BUFFER_DEPTH = 2
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [1:0] base_select_in,
   input wire logic [9:0] host_addr_in,
   input wire logic host_read_in,
   input wire logic host_write_in,
   input wire logic [7:0] host_wdata_in,
   output logic [7:0] host_rdata_out,
   output logic host_rdata_valid_out,
   input wire logic link_rx_valid_in,
   input wire logic [7:0] link_rx_byte_in,
   output logic link_rx_ready_out,
   output logic link_tx_valid_out,
   output logic [7:0] link_tx_byte_out,
   output logic link_tx_last_out,
   input wire logic link_tx_ready_in,
   input wire logic setup_line_in,
   input wire logic interrupt_acknowledge_n_in,
   input wire logic [HLBP_FLAG_LINES-1:0] flag_value_in,
   input wire logic [HLBP_FLAG_LINES-1:0] flag_drive_in,
   input wire logic [HLBP_FLAG_LINES-1:0] interrupt_flag_lines_in,
   output logic [HLBP_FLAG_LINES-1:0] interrupt_flag_lines_out,
   output logic [HLBP_FLAG_LINES-1:0] interrupt_flag_lines_oe_out,
   output logic global_restart_out
);
   // Base decode, shared by read and write paths
   function automatic logic block_hit(input logic [9:0] addr, input logic [1:0] sel);
      logic [9:0] base;
      case (sel)
         2'h0: base = HLBP_BASE_0;
         2'h1: base = HLBP_BASE_1;
         2'h2: base = HLBP_BASE_2;
         default: base = HLBP_BASE_3;
      endcase
      return (addr[9:3] == base[9:3]) && (addr[2:0] <= HLBP_OFF_RESTART);
   endfunction

   logic rd_hit;
   logic wr_hit;
   logic [2:0] offset;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic rx_pop;
   logic tx_push;
   logic tx_in_ready;
   logic tx_buf_valid;
   logic [8:0] tx_buf_word;
   logic tx_take;
   logic tx_idle;
   logic setup_level;
   logic ack_n_level;
   logic [1:0] rx_lane;
   logic [1:0] tx_lane;
   logic [1:0] next_rx_lane;
   logic [1:0] next_tx_lane;
   logic [7:0] next_rdata;
   logic next_rdata_valid;
   logic next_restart;
   logic next_tx_valid;
   logic [7:0] next_tx_byte;
   logic next_tx_last;
   hlbp_boot_type boot_state;
   hlbp_boot_type next_boot_state;
   logic [HLBP_FLAG_LINES-1:0] next_flag_out;
   logic [HLBP_FLAG_LINES-1:0] next_flag_oe;

   // Pin inputs cross in through three stages
   hlbp_pin_sync #(
      .WIDTH(2),
      .RESET_VALUE(2'h3)
   ) u_pin_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .pin_in({setup_line_in, interrupt_acknowledge_n_in}),
      .level_out({setup_level, ack_n_level})
   );

   // Link to host bytes; stalls the link rather than dropping
   hlbp_byte_buffer #(
      .WIDTH(8),
      .DEPTH(BUFFER_DEPTH)
   ) u_rx_buffer (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .in_valid_in(link_rx_valid_in),
      .in_data_in(link_rx_byte_in),
      .in_ready_out(link_rx_ready_out),
      .out_valid_out(rx_valid),
      .out_data_out(rx_byte),
      .out_ready_in(rx_pop)
   );

   // Host to link bytes, tagged with the end of word
   hlbp_byte_buffer #(
      .WIDTH(9),
      .DEPTH(BUFFER_DEPTH)
   ) u_tx_buffer (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .in_valid_in(tx_push),
      .in_data_in({tx_lane == HLBP_LAST_LANE, host_wdata_in}),
      .in_ready_out(tx_in_ready),
      .out_valid_out(tx_buf_valid),
      .out_data_out(tx_buf_word),
      .out_ready_in(tx_take)
   );

   // Address decode and data movement strobes
   always_comb
   begin
      offset = host_addr_in[2:0];
      rd_hit = host_read_in && block_hit(host_addr_in, base_select_in);
      wr_hit = host_write_in && block_hit(host_addr_in, base_select_in);
      rx_pop = rd_hit && (offset == HLBP_OFF_RX_BYTE) && rx_valid;
      // A write into a full buffer is ignored; host polls status first
      tx_push = wr_hit && (offset == HLBP_OFF_TX_BYTE) && tx_in_ready;
      tx_take = !link_tx_valid_out || link_tx_ready_in;
      tx_idle = !tx_buf_valid && !link_tx_valid_out;
   end

   // Register read mux; unused bits and empty reads give zero
   always_comb
   begin
      next_rdata = host_rdata_out;
      next_rdata_valid = rd_hit;
      if (rd_hit)
      begin
         next_rdata = HLBP_RDATA_RESET;
         case (offset)
            HLBP_OFF_RX_BYTE: next_rdata = rx_valid ? rx_byte : HLBP_RDATA_RESET;
            HLBP_OFF_RX_STATUS:
            begin
               next_rdata[HLBP_READY_BIT] = rx_valid;
               next_rdata[1:0] = rx_lane;
            end
            HLBP_OFF_TX_STATUS:
            begin
               next_rdata[HLBP_READY_BIT] = tx_idle;
               next_rdata[1:0] = tx_lane;
            end
            HLBP_OFF_SETUP: next_rdata[HLBP_SETUP_BIT] = setup_level;
            HLBP_OFF_RESTART: next_rdata[HLBP_RESTART_BIT] = global_restart_out;
            default: next_rdata = HLBP_RDATA_RESET;
         endcase
      end
   end

   // Byte lanes within a word; software reads them to stay aligned
   always_comb
   begin
      next_rx_lane = rx_pop ? rx_lane + 2'h1 : rx_lane;
      next_tx_lane = tx_push ? tx_lane + 2'h1 : tx_lane;
   end

   // Restart bit is level-held, so a toggle sequence asserts then releases
   always_comb
   begin
      next_restart = global_restart_out;
      if (wr_hit && (offset == HLBP_OFF_RESTART))
      begin
         next_restart = host_wdata_in[HLBP_RESTART_BIT];
      end
   end

   // Output stage so link pins come straight from flops
   always_comb
   begin
      next_tx_valid = link_tx_valid_out;
      next_tx_byte = link_tx_byte_out;
      next_tx_last = link_tx_last_out;
      if (tx_take)
      begin
         next_tx_valid = tx_buf_valid;
         // An empty buffer slot holds no data, so keep the last byte
         if (tx_buf_valid)
         begin
            next_tx_byte = tx_buf_word[7:0];
            next_tx_last = tx_buf_word[8];
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         host_rdata_out <= HLBP_RDATA_RESET;
         host_rdata_valid_out <= 1'b0;
         global_restart_out <= HLBP_RESTART_RESET;
         rx_lane <= 2'h0;
         tx_lane <= 2'h0;
         link_tx_valid_out <= 1'b0;
         link_tx_byte_out <= 8'h00;
         link_tx_last_out <= 1'b0;
      end
      else
      begin
         host_rdata_out <= next_rdata;
         host_rdata_valid_out <= next_rdata_valid;
         global_restart_out <= next_restart;
         rx_lane <= next_rx_lane;
         tx_lane <= next_tx_lane;
         link_tx_valid_out <= next_tx_valid;
         link_tx_byte_out <= next_tx_byte;
         link_tx_last_out <= next_tx_last;
      end
   end

   // Boot guard: reset holds flag drivers off so the processor
   // samples its pulled-up boot selection undisturbed
   always_comb
   begin
      next_boot_state = boot_state;
      case (boot_state)
         HLBP_BOOT_HOLD: if (!ack_n_level) next_boot_state = HLBP_BOOT_DONE;
         HLBP_BOOT_DONE: next_boot_state = HLBP_BOOT_DONE;
         default: next_boot_state = HLBP_BOOT_HOLD;
      endcase
      next_flag_out = flag_value_in;
      next_flag_oe = (next_boot_state == HLBP_BOOT_DONE) ? flag_drive_in : '0;
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         boot_state <= HLBP_BOOT_HOLD;
         interrupt_flag_lines_out <= '0;
         interrupt_flag_lines_oe_out <= '0;
      end
      else
      begin
         boot_state <= next_boot_state;
         interrupt_flag_lines_out <= next_flag_out;
         interrupt_flag_lines_oe_out <= next_flag_oe;
      end
   end

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   sequence rx_read_s;
      rd_hit && offset == HLBP_OFF_RX_BYTE && rx_valid;
   endsequence

   sequence ack_seen_s;
      boot_state == HLBP_BOOT_HOLD && !ack_n_level;
   endsequence

   rx_read_data_a: assert property (rx_read_s |=> host_rdata_out == $past(rx_byte) && host_rdata_valid_out)
      else $error("read data not the waiting byte");
   rx_status_a: assert property (rd_hit && offset == HLBP_OFF_RX_STATUS |=>
      host_rdata_out[HLBP_READY_BIT] == $past(rx_valid))
      else $error("input status bit wrong");
   tx_status_a: assert property (rd_hit && offset == HLBP_OFF_TX_STATUS |=>
      host_rdata_out[HLBP_READY_BIT] == $past(tx_idle))
      else $error("output status bit wrong");
   setup_read_a: assert property (rd_hit && offset == HLBP_OFF_SETUP |=>
      host_rdata_out == {7'h00, $past(setup_level)})
      else $error("setup line readback wrong");
   // Back-to-back restart writes are legal, so each write is judged alone
   restart_write_a: assert property (wr_hit && offset == HLBP_OFF_RESTART |=>
      global_restart_out == $past(host_wdata_in[HLBP_RESTART_BIT]))
      else $error("restart bit not taken");
   restart_hold_a: assert property (!(wr_hit && offset == HLBP_OFF_RESTART) |=>
      $stable(global_restart_out))
      else $error("restart bit moved without a write");
   base_decode_a: assert property (host_read_in && !block_hit(host_addr_in, base_select_in) |=>
      !host_rdata_valid_out)
      else $error("read answered outside base");
   flags_off_a: assert property (boot_state == HLBP_BOOT_HOLD |=>
      interrupt_flag_lines_oe_out == '0 || boot_state == HLBP_BOOT_DONE)
      else $error("flag lines driven during boot");
   boot_release_a: assert property (ack_seen_s |=>
      boot_state == HLBP_BOOT_DONE && interrupt_flag_lines_oe_out == $past(flag_drive_in))
      else $error("guard not released on acknowledge");
   tx_busy_a: assert property (tx_push |=> !tx_idle)
      else $error("output status not cleared by write");
   rx_consume_a: assert property (rx_read_s ##0 !link_rx_valid_in && rx_lane == 2'h0 |=> rx_lane == 2'h1)
      else $error("read did not consume byte");
   tx_hold_a: assert property (link_tx_valid_out && !link_tx_ready_in |=>
      link_tx_valid_out && $stable(link_tx_byte_out))
      else $error("link byte changed while stalled");
endmodule

// *** shared/hlbp_pkg.sv ***
// Purpose: Shared constants for the host link byte port.
// Assumes: Byte-wide host I/O bus, 10-bit I/O addresses.
// Notes: Offsets are byte locations from the selected base.
package hlbp_pkg;
   // Register offsets within the block
   localparam logic [2:0] HLBP_OFF_RX_BYTE = 3'h0;
   localparam logic [2:0] HLBP_OFF_TX_BYTE = 3'h1;
   localparam logic [2:0] HLBP_OFF_RX_STATUS = 3'h2;
   localparam logic [2:0] HLBP_OFF_TX_STATUS = 3'h3;
   localparam logic [2:0] HLBP_OFF_SETUP = 3'h4;
   localparam logic [2:0] HLBP_OFF_RESTART = 3'h5;
   // Selectable base addresses in I/O space
   localparam logic [9:0] HLBP_BASE_0 = 10'h150;
   localparam logic [9:0] HLBP_BASE_1 = 10'h200;
   localparam logic [9:0] HLBP_BASE_2 = 10'h300;
   localparam logic [9:0] HLBP_BASE_3 = 10'h380;
   // Field positions
   localparam int HLBP_READY_BIT = 7;
   localparam int HLBP_RESTART_BIT = 0;
   localparam int HLBP_SETUP_BIT = 0;
   // Reset values and idle answers
   localparam logic [7:0] HLBP_RDATA_RESET = 8'h00;
   localparam logic HLBP_RESTART_RESET = 1'b0;
   // Last byte lane of a four-byte link word
   localparam logic [1:0] HLBP_LAST_LANE = 2'h3;
   localparam int HLBP_FLAG_LINES = 4;
   // Bootstrap guard states, Gray along the path
   typedef enum logic [1:0]
   {
      HLBP_BOOT_HOLD = 2'b00,
      HLBP_BOOT_DONE = 2'b01
   } hlbp_boot_type;
endpackage

// *** rtl/hlbp_pin_sync.sv ***
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_in.
// Notes: Output changes only when stages two and three agree.
`timescale 1ns/100ps
module hlbp_pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_level;

   // Per bit, accept a change once two settled stages match
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
      end
   end

   // Stage one feeds stage two only, to keep metastability contained
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         stage1 <= RESET_VALUE;
         stage2 <= RESET_VALUE;
         stage3 <= RESET_VALUE;
         level_out <= RESET_VALUE;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level_out <= next_level;
      end
   end
endmodule

// *** rtl/hlbp_byte_buffer.sv ***
// Purpose: Small valid/ready FIFO in the data path.
// Assumes: DEPTH is a power of two, at least two.
// Notes: Ready and valid are registered from the next count.
`timescale 1ns/100ps
module hlbp_byte_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic [PW-1:0] next_wr_ptr;
   logic [PW-1:0] next_rd_ptr;
   logic [PW:0] next_count;
   logic push;
   logic pop;

   // Pointer and count update; a push into a full store is impossible
   always_comb
   begin
      push = in_valid_in && in_ready_out;
      pop = out_valid_out && out_ready_in;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_out <= 1'b1;
         out_valid_out <= 1'b0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready_out <= next_count != FULL_COUNT;
         out_valid_out <= next_count != '0;
      end
   end

   // Storage holds no control state, so it needs no reset
   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         store[wr_ptr] <= in_data_in;
      end
   end

   assign out_data_out = store[rd_ptr];

   no_overflow_a: assert property (@(posedge clk_in) disable iff (reset_in) count <= FULL_COUNT)
      else $error("buffer count above depth");
endmodule

// *** bench/hlbp_link_model.sv ***
// Purpose: Behavioural processor link partner for the host port.
// Assumes: Byte valid/ready link on clk_in, driven at the rising edge.
// Notes: Idle receive data toggles so stale bytes never look valid.
`timescale 1ns/100ps
module hlbp_link_model (
   input wire logic clk_in,
   input wire logic stall_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_last_in,
   input wire logic rx_ready_in,
   output logic rx_valid_out,
   output logic [7:0] rx_byte_out,
   output logic tx_ready_out
);
   logic [7:0] send_q[$];
   logic [7:0] got_q[$];
   logic got_last[$];
   // Words leave as four bytes, low byte first
   task automatic push_word(input logic [31:0] w);
      for (int i = 0; i < 4; i++)
      begin
         send_q.push_back(w[8*i +: 8]);
      end
   endtask
   initial
   begin
      rx_valid_out = 1'b0;
      rx_byte_out = 8'h00;
      tx_ready_out = 1'b0;
   end
   // Byte held until taken; stall withholds ready to back up the port
   always @(posedge clk_in)
   begin
      if (tx_valid_in && tx_ready_out)
      begin
         got_q.push_back(tx_byte_in);
         got_last.push_back(tx_last_in);
      end
      if (rx_valid_out && rx_ready_in)
      begin
         void'(send_q.pop_front());
      end
      tx_ready_out <= !stall_in;
      if (send_q.size() > 0)
      begin
         rx_valid_out <= 1'b1;
         rx_byte_out <= send_q[0];
      end
      else
      begin
         rx_valid_out <= 1'b0;
         rx_byte_out <= ~rx_byte_out; // Released line, no stale value
      end
   end
endmodule

// *** bench/host_link_byte_port_tb_top.sv ***
// Purpose: Self-checking bench for the host link byte port.
// Assumes: Host strobes set on the falling edge, one cycle long.
// Notes: Read answers are sampled at the falling edge after the strobe.
`timescale 1ns/100ps
module host_link_byte_port_tb_top;
   import hlbp_pkg::*;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [1:0] base_select_in = 2'h0;
   logic [9:0] host_addr_in = 10'h000;
   logic host_read_in = 1'b0;
   logic host_write_in = 1'b0;
   logic [7:0] host_wdata_in = 8'h00;
   logic setup_line_in = 1'b1;
   logic ack_n = 1'b1;
   logic [3:0] flag_value_in = 4'hA;
   logic [3:0] flag_drive_in = 4'hF;
   logic stall = 1'b0;
   logic [7:0] host_rdata_out, rx_byte, tx_byte;
   logic host_rdata_valid_out, rx_valid, rx_ready, tx_valid, tx_last, tx_ready, restart;
   logic [3:0] flag_out, flag_oe, flag_lines;
   logic [9:0] base_tab [4] = '{HLBP_BASE_0, HLBP_BASE_1, HLBP_BASE_2, HLBP_BASE_3};
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Clock, 10 ns period
   always #5 clk_in = ~clk_in;
   // Flag lines pulled high while nobody drives them
   assign flag_lines = (flag_oe & flag_out) | ~flag_oe;
   hlbp_host_port dut_u (.clk_in(clk_in), .reset_in(reset_in), .base_select_in(base_select_in),
      .host_addr_in(host_addr_in), .host_read_in(host_read_in), .host_write_in(host_write_in),
      .host_wdata_in(host_wdata_in), .host_rdata_out(host_rdata_out),
      .host_rdata_valid_out(host_rdata_valid_out), .link_rx_valid_in(rx_valid),
      .link_rx_byte_in(rx_byte), .link_rx_ready_out(rx_ready), .link_tx_valid_out(tx_valid),
      .link_tx_byte_out(tx_byte), .link_tx_last_out(tx_last), .link_tx_ready_in(tx_ready),
      .setup_line_in(setup_line_in), .interrupt_acknowledge_n_in(ack_n),
      .flag_value_in(flag_value_in), .flag_drive_in(flag_drive_in),
      .interrupt_flag_lines_in(flag_lines), .interrupt_flag_lines_out(flag_out),
      .interrupt_flag_lines_oe_out(flag_oe), .global_restart_out(restart));
   hlbp_link_model link_u (.clk_in(clk_in), .stall_in(stall), .tx_valid_in(tx_valid),
      .tx_byte_in(tx_byte), .tx_last_in(tx_last), .rx_ready_in(rx_ready),
      .rx_valid_out(rx_valid), .rx_byte_out(rx_byte), .tx_ready_out(tx_ready));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One host access; strobe held for exactly one rising edge
   task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic vld);
      @(negedge clk_in);
      host_addr_in = a;
      host_read_in = !wr;
      host_write_in = wr;
      host_wdata_in = wd;
      @(negedge clk_in);
      rd = host_rdata_out;
      vld = host_rdata_valid_out;
      host_read_in = 1'b0;
      host_write_in = 1'b0;
   endtask
   task automatic rd_off(input logic [2:0] off, output logic [7:0] rd);
      logic v;
      acc(1'b0, base_tab[base_select_in] + {7'h00, off}, 8'h00, rd, v);
      check("read answer valid", 8'h01, {7'h00, v});
   endtask
   task automatic wr_off(input logic [2:0] off, input logic [7:0] d);
      logic [7:0] r;
      logic v;
      acc(1'b1, base_tab[base_select_in] + {7'h00, off}, d, r, v);
   endtask
   task automatic t_reset;
      logic [7:0] r;
      check("flag enables", 8'h00, {4'h0, flag_oe});
      check("restart line", 8'h00, {7'h00, restart});
      rd_off(HLBP_OFF_TX_STATUS, r);
      check("tx ready idle", 8'h80, r & 8'h80);
      rd_off(HLBP_OFF_RX_STATUS, r);
      check("rx waiting idle", 8'h00, r & 8'h80);
      rd_off(HLBP_OFF_TX_BYTE, r);
      check("write-only read", 8'h00, r);
   endtask
   // Host writes one word while the link stalls each byte
   task automatic t_tx;
      logic [7:0] r;
      logic [31:0] w;
      int n;
      w = 32'hA1B2C3D4;
      stall = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr_off(HLBP_OFF_TX_BYTE, w[8*i +: 8]);
         rd_off(HLBP_OFF_TX_STATUS, r);
         check("tx ready after write", 8'h00, r & 8'h80);
         stall = 1'b0;
         n = 0;
         while (r[7] !== 1'b1 && n < 50)
         begin
            rd_off(HLBP_OFF_TX_STATUS, r);
            n++;
         end
         check("tx ready after send", 8'h80, r & 8'h80);
         stall = 1'b1;
      end
      stall = 1'b0;
      check("tx byte count", 8'h04, 8'(link_u.got_q.size()));
      for (int i = 0; i < 4; i++)
      begin
         check("tx byte", w[8*i +: 8], link_u.got_q[i]);
         check("tx last", {7'h00, i == 3}, {7'h00, link_u.got_last[i]});
      end
   endtask
   // Link fills the receive buffer before the host reads
   task automatic t_rx;
      logic [7:0] r;
      logic [31:0] w;
      w = 32'h5A6B7C8D;
      link_u.push_word(w);
      repeat (10) @(negedge clk_in);
      check("rx ready when full", 8'h00, {7'h00, rx_ready});
      for (int i = 0; i < 4; i++)
      begin
         rd_off(HLBP_OFF_RX_STATUS, r);
         check("rx waiting", 8'h80, r & 8'h80);
         rd_off(HLBP_OFF_RX_BYTE, r);
         check("rx byte", w[8*i +: 8], r);
      end
      rd_off(HLBP_OFF_RX_STATUS, r);
      check("rx drained", 8'h00, r & 8'h80);
      rd_off(HLBP_OFF_RX_BYTE, r);
      check("empty read", 8'h00, r);
   endtask
   task automatic t_setup_restart;
      logic [7:0] r;
      for (int k = 0; k < 2; k++)
      begin
         setup_line_in = k[0];
         repeat (6) @(negedge clk_in);
         rd_off(HLBP_OFF_SETUP, r);
         check("setup level", {7'h00, k[0]}, r & 8'h01);
         wr_off(HLBP_OFF_RESTART, {7'h00, !k[0]});
         check("restart line", {7'h00, !k[0]}, {7'h00, restart});
         rd_off(HLBP_OFF_RESTART, r);
         check("restart readback", {7'h00, !k[0]}, r & 8'h01);
      end
      // A write to a read-only offset must leave the restart line alone
      wr_off(HLBP_OFF_SETUP, 8'h01);
      check("restart after ro write", 8'h00, {7'h00, restart});
   endtask
   // Every base choice decodes; the address past the block does not
   task automatic t_base;
      logic [7:0] r, q;
      logic v;
      for (int s = 0; s < 4; s++)
      begin
         base_select_in = s[1:0];
         rd_off(HLBP_OFF_TX_STATUS, r);
         check("tx ready at base", 8'h80, r & 8'h80);
         acc(1'b0, base_tab[s] + 10'h006, 8'h00, q, v);
         check("unmapped valid", 8'h00, {7'h00, v});
         check("unmapped data held", r, q);
      end
      base_select_in = 2'h0;
   endtask
   task automatic t_boot;
      check("flags before ack", 8'h00, {4'h0, flag_oe});
      ack_n = 1'b0;
      repeat (8) @(negedge clk_in);
      ack_n = 1'b1;
      check("flags after ack", 8'h0F, {4'h0, flag_oe});
      check("flag values", 8'h0A, {4'h0, flag_out});
      flag_drive_in = 4'h5;
      repeat (3) @(negedge clk_in);
      check("flag drive follows", 8'h05, {4'h0, flag_oe});
   endtask
   task automatic give_verdict;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (2) @(negedge clk_in);
      reset_in = 1'b0;
      t_reset();
      t_tx();
      t_rx();
      t_setup_restart();
      t_base();
      t_boot();
      give_verdict();
   end
endmodule
